/* File: srp_defines.svh */
// Constants for the serial result port: widths, edge counts and timing
`ifndef SRP_DEFINES_SVH
`define SRP_DEFINES_SVH

// Result word and frame length
`define SRP_DATA_W 14
`define SRP_CNT_W 5
`define SRP_END_EDGE 5'h11

// Core clock and conversion timing
`define SRP_CLK_NS 20
`define SRP_CONV_MAX_NS 2670
`define SRP_CONV_CYCLES (`SRP_CONV_MAX_NS / `SRP_CLK_NS)
`define SRP_CONV_CNT_W 8

// Reset values
`define SRP_RESULT_RST 14'h0000
`define SRP_GRAY_RST 5'h00
`define SRP_PINS_RST 2'h3

`endif

/* File: srp_pkg.sv */
// Types shared by the serial result port modules
package srp_pkg;

  // Frame sequencer states
  typedef enum logic [1:0] {
    FR_IDLE    = 2'b00,
    FR_WAIT_FS = 2'b01,
    FR_SHIFT   = 2'b10,
    FR_DONE    = 2'b11
  } srp_frame_t;

  // Converter timing states
  typedef enum logic [1:0] {
    CV_CONVERT = 2'b00,
    CV_SLEEP   = 2'b01
  } srp_conv_t;

  // Host control pins after synchronisation
  typedef struct packed {
    logic cs_n;
    logic frame_sync;
  } srp_pins_t;

  // Serial result pin drive
  typedef struct packed {
    logic data;
    logic oe;
  } srp_sdo_t;

endpackage : srp_pkg

/* File: srp_sync2.sv */
// Two-flop synchroniser for levels and gray-coded words
`timescale 1ns/1ns
module srp_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule : srp_sync2

/* File: srp_gray_count.sv */
// Serial clock edge counter, gray coded for crossing to the core clock
`timescale 1ns/1ns
`include "srp_defines.svh"
module srp_gray_count
  import srp_pkg::*;
#(
  parameter int W = `SRP_CNT_W
) (
  // Link clock and reset
  input wire logic sclk,
  input wire logic rst_n,
  // Count of rising edges, gray coded
  output logic [W-1:0] gray
);

  logic [W-1:0] bin;
  logic [W-1:0] next_bin;
  logic [W-1:0] next_gray;

  // One step per rising serial clock edge
  always_comb begin
    next_bin = bin + W'(1);
    next_gray = next_bin ^ (next_bin >> 1);
  end

  // Only one gray bit changes per edge
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      bin <= '0;
      gray <= '0;
    end else begin
      bin <= next_bin;
      gray <= next_gray;
    end
  end

endmodule : srp_gray_count

/* File: srp_result_port.sv */
// Serial result port: frame sequencing, bit output and conversion timing
//
// What this block does
// - With frame sync high, a falling chip select takes the result output out of high impedance.
// - A rising frame sync starts a frame, driving the output with the top bit.
// - While chip select is high the result output stays in high impedance.
// - The result leaves top bit first, each later bit placed at a rising serial clock.
// - With frame sync high at the chip select fall, the top bit appears at that fall.
// - With frame sync low at the chip select fall, the top bit waits for a frame sync rise.
// - In frame sync mode bits change on rising serial clock, the host samples on falling.
// - The output returns to high impedance after the seventeenth rising serial clock.
// - Without a seventeenth clock the output goes high impedance at the chip select rise.
// - Each delivered conversion result is fourteen bits wide.
// - Conversions are timed by the internal clock and end within 2.67 microseconds.
// - The converter powers down on its own when idle and wakes for the next conversion.
`timescale 1ns/1ns
`include "srp_defines.svh"
module srp_result_port
  import srp_pkg::*;
#(
  parameter int DATA_W = `SRP_DATA_W,
  parameter int CNT_W = `SRP_CNT_W,
  parameter int CONV_CYCLES = `SRP_CONV_CYCLES
) (
  // Core clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // Host link
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic FRAME_SYNC_IN,
  output logic SERIAL_RESULT_OUT,
  output logic SERIAL_RESULT_OE,
  // Converter core
  input wire logic [DATA_W-1:0] ANALOG_INPUT,
  output logic POWER_DOWN,
  output logic CONV_BUSY
);

  localparam logic [`SRP_CONV_CNT_W-1:0] CONV_LAST = `SRP_CONV_CNT_W'(CONV_CYCLES - 1);
  localparam logic [CNT_W-1:0] END_EDGE = `SRP_END_EDGE;
  localparam logic [CNT_W-1:0] LAST_DATA = CNT_W'(DATA_W);

  // Gray to binary conversion of the crossed edge count
  function automatic logic [CNT_W-1:0] gray2bin(input logic [CNT_W-1:0] g);
    logic [CNT_W-1:0] b;
    b = '0;
    for (int i = CNT_W - 1; i >= 0; i--) begin
      if (i == CNT_W - 1) begin
        b[i] = g[i];
      end else begin
        b[i] = b[i+1] ^ g[i];
      end
    end
    return b;
  endfunction : gray2bin

  // Link clock domain and crossings
  logic [CNT_W-1:0] edge_gray;
  logic [CNT_W-1:0] edge_gray_sync;
  srp_pins_t pins_raw;
  srp_pins_t pins_sync;

  // Rising serial clock edges counted in the link domain
  srp_gray_count #(
    .W(CNT_W)
  ) u_edge_count (
    .sclk(SCLK),
    .rst_n(RSTN),
    .gray(edge_gray)
  );

  // Gray count crosses into the core domain
  srp_sync2 #(
    .W(CNT_W),
    .RST_VAL(`SRP_GRAY_RST)
  ) u_edge_sync (
    .clk(CLK),
    .rst_n(RSTN),
    .d(edge_gray),
    .q(edge_gray_sync)
  );

  // Chip select and frame sync pins synchronised
  assign pins_raw.cs_n = CS_N;
  assign pins_raw.frame_sync = FRAME_SYNC_IN;

  srp_sync2 #(
    .W(2),
    .RST_VAL(`SRP_PINS_RST)
  ) u_pin_sync (
    .clk(CLK),
    .rst_n(RSTN),
    .d(pins_raw),
    .q(pins_sync)
  );

  // Frame sequencer and serial output
  srp_pins_t pins_prev;
  srp_frame_t frame_state;
  logic [CNT_W-1:0] edge_base;
  logic [DATA_W-1:0] frame_word;
  logic fs_mode;
  srp_sdo_t serial_result_out;
  logic [DATA_W-1:0] result;

  srp_pins_t next_pins_prev;
  srp_frame_t next_frame_state;
  logic [CNT_W-1:0] next_edge_base;
  logic [DATA_W-1:0] next_frame_word;
  logic next_fs_mode;
  srp_sdo_t next_sdo;
  logic frame_end;

  logic [CNT_W-1:0] edge_now;
  logic [CNT_W-1:0] edge_idx;
  logic [DATA_W-1:0] word_shifted;
  logic cs_fall;
  logic cs_rise;
  logic fs_rise;
  logic cs_low;

  // Edge detection on synchronised pins and bit position in frame
  always_comb begin
    edge_now = gray2bin(edge_gray_sync);
    edge_idx = edge_now - edge_base;
    word_shifted = frame_word << edge_idx;
    cs_low = ~pins_sync.cs_n;
    cs_fall = pins_prev.cs_n & ~pins_sync.cs_n;
    cs_rise = ~pins_prev.cs_n & pins_sync.cs_n;
    fs_rise = ~pins_prev.frame_sync & pins_sync.frame_sync;
  end

  // Next state of the frame sequencer
  always_comb begin
    next_pins_prev = pins_sync;
    next_frame_state = frame_state;
    next_edge_base = edge_base;
    next_frame_word = frame_word;
    next_fs_mode = fs_mode;
    next_sdo = serial_result_out;
    frame_end = 1'b0;
    case (frame_state)
      FR_IDLE: begin
        next_sdo.oe = 1'b0;
        if (cs_fall && pins_sync.frame_sync) begin
          // Frame sync unused: top bit at chip select fall
          next_fs_mode = 1'b0;
          next_frame_state = FR_SHIFT;
          next_edge_base = edge_now;
          next_frame_word = result;
          next_sdo.data = result[DATA_W-1];
          next_sdo.oe = 1'b1;
        end else if (cs_fall) begin
          // Frame sync active: wait for its rising edge
          next_fs_mode = 1'b1;
          next_frame_state = FR_WAIT_FS;
        end else if (cs_low && fs_rise) begin
          // Chip select held low, frame started by frame sync
          next_fs_mode = 1'b1;
          next_frame_state = FR_SHIFT;
          next_edge_base = edge_now;
          next_frame_word = result;
          next_sdo.data = result[DATA_W-1];
          next_sdo.oe = 1'b1;
        end
      end
      FR_WAIT_FS: begin
        next_sdo.oe = 1'b0;
        if (!cs_low) begin
          next_frame_state = FR_IDLE;
        end else if (fs_rise) begin
          next_frame_state = FR_SHIFT;
          next_edge_base = edge_now;
          next_frame_word = result;
          next_sdo.data = result[DATA_W-1];
          next_sdo.oe = 1'b1;
        end
      end
      FR_SHIFT: begin
        if (!cs_low) begin
          // Host stopped short of the last edge
          next_frame_state = FR_IDLE;
          next_sdo.oe = 1'b0;
          frame_end = 1'b1;
        end else if (edge_idx >= END_EDGE) begin
          next_frame_state = FR_DONE;
          next_sdo.oe = 1'b0;
          frame_end = 1'b1;
        end else if (edge_idx < LAST_DATA) begin
          // Bit follows each rising serial clock edge
          next_sdo.data = word_shifted[DATA_W-1];
        end else begin
          next_sdo.data = 1'b0; // Past the last data bit
        end
      end
      FR_DONE: begin
        next_sdo.oe = 1'b0;
        if (!cs_low) begin
          next_frame_state = FR_IDLE;
        end else if (fs_mode) begin
          next_frame_state = FR_WAIT_FS;
        end
      end
      default: begin
        next_frame_state = FR_IDLE;
        next_sdo.oe = 1'b0;
      end
    endcase
  end

  // Frame sequencer registers
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      pins_prev <= `SRP_PINS_RST;
      frame_state <= FR_IDLE;
      edge_base <= '0;
      frame_word <= `SRP_RESULT_RST;
      fs_mode <= 1'b0;
      serial_result_out <= '0;
    end else begin
      pins_prev <= next_pins_prev;
      frame_state <= next_frame_state;
      edge_base <= next_edge_base;
      frame_word <= next_frame_word;
      fs_mode <= next_fs_mode;
      serial_result_out <= next_sdo;
    end
  end

  // Serial pin straight from its register
  assign SERIAL_RESULT_OUT = serial_result_out.data;
  assign SERIAL_RESULT_OE = serial_result_out.oe;

  // Conversion timing and automatic power down
  srp_conv_t conv_state;
  logic [`SRP_CONV_CNT_W-1:0] conv_cnt;
  logic power_down;
  logic conv_busy;

  srp_conv_t next_conv_state;
  logic [`SRP_CONV_CNT_W-1:0] next_conv_cnt;
  logic [DATA_W-1:0] next_result;
  logic next_power_down;
  logic next_conv_busy;

  // Next state of the converter timer
  always_comb begin
    next_conv_state = conv_state;
    next_conv_cnt = conv_cnt;
    next_result = result;
    case (conv_state)
      CV_CONVERT: begin
        // Internal clock times the conversion
        if (conv_cnt == CONV_LAST) begin
          next_result = ANALOG_INPUT;
          next_conv_cnt = '0;
          next_conv_state = CV_SLEEP;
        end else begin
          next_conv_cnt = conv_cnt + `SRP_CONV_CNT_W'(1);
        end
      end
      CV_SLEEP: begin
        // End of a frame wakes the converter
        if (frame_end) begin
          next_conv_cnt = '0;
          next_conv_state = CV_CONVERT;
        end
      end
      default: begin
        next_conv_cnt = '0;
        next_conv_state = CV_SLEEP;
      end
    endcase
    next_power_down = (next_conv_state == CV_SLEEP);
    next_conv_busy = (next_conv_state == CV_CONVERT);
  end

  // Converter registers, a first conversion runs after reset
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      conv_state <= CV_CONVERT;
      conv_cnt <= '0;
      result <= `SRP_RESULT_RST;
      power_down <= 1'b0;
      conv_busy <= 1'b1;
    end else begin
      conv_state <= next_conv_state;
      conv_cnt <= next_conv_cnt;
      result <= next_result;
      power_down <= next_power_down;
      conv_busy <= next_conv_busy;
    end
  end

  // Status outputs from registers
  assign POWER_DOWN = power_down;
  assign CONV_BUSY = conv_busy;

endmodule : srp_result_port

/* File: srp_result_port_assertions.sv */
// Checker for the serial result port pins
`timescale 1ns/1ns
module srp_result_port_assertions #(
  parameter int DATA_W = 14,
  parameter int CNT_W = 5,
  parameter int CONV_CYCLES = 133
) (
  // Core clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // Host link and converter
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic FRAME_SYNC_IN,
  input wire logic SERIAL_RESULT_OUT,
  input wire logic SERIAL_RESULT_OE,
  input wire logic [DATA_W-1:0] ANALOG_INPUT,
  input wire logic POWER_DOWN,
  input wire logic CONV_BUSY
);
  logic sclk_q;
  logic [4:0] rises;
  logic [3:0] since;
  int busy;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // Rises in frame, cycles since a rise, length of busy
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      sclk_q <= 1'b1;
      rises <= '0;
      since <= '0;
      busy <= 0;
    end else begin
      sclk_q <= SCLK;
      rises <= !SERIAL_RESULT_OE ? 5'h00 : rises + 5'(SCLK && !sclk_q);
      since <= (SCLK && !sclk_q) ? 4'h0 : since + 4'(since != 4'hF);
      busy <= CONV_BUSY ? busy + 1 : 0;
    end
  end
  a_cs_high_hiz: assert property (CS_N [*6] |-> !SERIAL_RESULT_OE)
    else $error("result pin driven while deselected");
  a_spi_start: assert property ($fell(CS_N) && FRAME_SYNC_IN |-> ##[2:5] SERIAL_RESULT_OE)
    else $error("no drive after select fall");
  a_sync_wait: assert property ($fell(CS_N) && !FRAME_SYNC_IN |-> !SERIAL_RESULT_OE [*4])
    else $error("drive before frame sync rise");
  a_sync_start: assert property ($rose(FRAME_SYNC_IN) && !CS_N && !$past(CS_N, 6)
    && !SERIAL_RESULT_OE |-> ##[2:5] SERIAL_RESULT_OE)
    else $error("no drive after frame sync rise");
  a_cs_rise_hiz: assert property ($rose(CS_N) |-> ##[1:5] !SERIAL_RESULT_OE)
    else $error("drive kept after select rise");
  a_bit_moves: assert property (SERIAL_RESULT_OE && $past(SERIAL_RESULT_OE)
    && $changed(SERIAL_RESULT_OUT) |-> since <= 4'h5)
    else $error("bit changed away from a clock rise");
  a_tail_zero: assert property (SERIAL_RESULT_OE && rises >= 5'd14 && since > 4'h5
    |-> !SERIAL_RESULT_OUT)
    else $error("bits past the word not zero");
  a_end_17: assert property (rises == 5'd17 |-> ##[0:5] !SERIAL_RESULT_OE)
    else $error("drive kept after last clock");
  a_conv_len: assert property ($fell(CONV_BUSY) |-> busy >= CONV_CYCLES - 1
    && busy <= CONV_CYCLES + 1)
    else $error("conversion length wrong");
  a_auto_sleep: assert property ($fell(CONV_BUSY) |-> POWER_DOWN)
    else $error("no sleep after conversion");
  a_wake: assert property ($fell(SERIAL_RESULT_OE) && $past(POWER_DOWN) |-> ##[0:3] CONV_BUSY)
    else $error("no wake after frame");
  // Main scenarios
  c_spi: cover property ($fell(CS_N) && FRAME_SYNC_IN);
  c_full: cover property (rises == 5'd17);
  c_conv: cover property ($fell(CONV_BUSY));
endmodule : srp_result_port_assertions

bind srp_result_port srp_result_port_assertions #(.DATA_W(DATA_W), .CNT_W(CNT_W),
  .CONV_CYCLES(CONV_CYCLES)) u_chk (.CLK(CLK), .RSTN(RSTN), .SCLK(SCLK), .CS_N(CS_N),
  .FRAME_SYNC_IN(FRAME_SYNC_IN), .SERIAL_RESULT_OUT(SERIAL_RESULT_OUT),
  .SERIAL_RESULT_OE(SERIAL_RESULT_OE), .ANALOG_INPUT(ANALOG_INPUT),
  .POWER_DOWN(POWER_DOWN), .CONV_BUSY(CONV_BUSY));

/* File: srp_host_model.sv */
// Host serial port model driving select, frame sync and serial clock
`timescale 1ns/1ns
module srp_host_model #(
  parameter int HALF = 125
) (
  // Link pins
  output logic sclk,
  output logic cs_n,
  output logic frame_sync_in,
  // Result pin level
  input wire logic res_pin
);
  // Clock idles high between frames
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    frame_sync_in = 1'b1;
  end
  // One frame of n clocks, bits taken at falling clock
  task automatic frame(input logic sync_mode, input int n, input logic end_cs,
    output logic [16:0] word);
    word = '0;
    if (sync_mode) begin
      frame_sync_in = 1'b0;
      #(HALF) cs_n = 1'b0;
      #(HALF) frame_sync_in = 1'b1;
    end else begin
      cs_n = 1'b1;
      frame_sync_in = 1'b1;
      #(HALF) cs_n = 1'b0;
    end
    #(2 * HALF);
    for (int i = 0; i < n; i++) begin
      sclk = 1'b0;
      word = {word[15:0], res_pin};
      frame_sync_in = !sync_mode;
      #(HALF) sclk = 1'b1;
      #(HALF);
    end
    if (end_cs) cs_n = 1'b1;
  endtask : frame
  // Clocks with nobody selected
  task automatic stray(input int n);
    repeat (n) begin
      #(HALF) sclk = 1'b0;
      #(HALF) sclk = 1'b1;
    end
  endtask : stray
endmodule : srp_host_model

/* File: srp_result_port_bench.sv */
// Bench for the serial result port with a host model
`timescale 1ns/1ns
module srp_result_port_bench
  import srp_pkg::*;
;
  logic clk;
  logic rstn;
  logic [13:0] sample;
  logic [13:0] cur;
  logic [13:0] prev;
  logic sclk;
  logic cs_n;
  logic frame_sync_in;
  logic res_data;
  logic res_oe;
  logic res_pin;
  logic power_down;
  logic conv_busy;
  logic [16:0] word;
  int bad_count = 0;
  int checked = 0;
  // Wire level of the three-state pin
  assign res_pin = res_oe ? res_data : 1'bz;
  srp_result_port #(.CONV_CYCLES(8)) u_dut (.CLK(clk), .RSTN(rstn), .SCLK(sclk), .CS_N(cs_n),
    .FRAME_SYNC_IN(frame_sync_in), .SERIAL_RESULT_OUT(res_data), .SERIAL_RESULT_OE(res_oe),
    .ANALOG_INPUT(sample), .POWER_DOWN(power_down), .CONV_BUSY(conv_busy));
  srp_host_model u_host (.sclk(sclk), .cs_n(cs_n), .frame_sync_in(frame_sync_in),
    .res_pin(res_pin));
  // Core clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic test_done();
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done
  // Waits for a conversion to start and end
  task automatic wait_conv();
    int i;
    for (i = 0; i < 20 && conv_busy !== 1'b1; i++) @(posedge clk);
    check("busy", 17'(conv_busy), 17'h1);
    for (i = 0; i < 12 && conv_busy !== 1'b0; i++) @(posedge clk);
    #1;
    check("sleep", 17'(power_down), 17'h1);
  endtask : wait_conv
  // One frame, next sample captured at its end
  task automatic run(input logic sync_mode, input int n, input logic end_cs,
    input logic [13:0] nxt);
    sample = nxt;
    u_host.frame(sync_mode, n, end_cs, word);
    wait_conv();
    prev = cur;
    cur = nxt;
  endtask : run
  task automatic t_spi();
    run(1'b0, 16, 1'b1, 14'h1F03);
    check("spi word", word, {1'h0, prev, 2'h0});
    check("cs release", 17'(res_oe), 17'h0);
    $display("t_spi done");
  endtask : t_spi
  task automatic t_sync();
    run(1'b1, 17, 1'b0, 14'h3C96);
    check("sync word", word, {prev, 3'h0});
    check("after 17th", 17'({cs_n, res_oe}), 17'h0);
    run(1'b1, 17, 1'b0, 14'h0A71);
    check("second sync word", word, {prev, 3'h0});
    $display("t_sync done");
  endtask : t_sync
  task automatic t_abort();
    run(1'b0, 5, 1'b1, 14'h2B4D);
    check("short word", word, 17'(prev[13:9]));
    u_host.stray(20);
    check("stray hiz", 17'(res_oe), 17'h0);
    run(1'b0, 16, 1'b1, 14'h1234);
    check("restart word", word, {1'h0, prev, 2'h0});
    $display("t_abort done");
  endtask : t_abort
  // Main sequence
  initial begin
    rstn = 1'b0;
    sample = 14'h2A5C;
    cur = 14'h2A5C;
    repeat (4) @(posedge clk);
    #1 rstn = 1'b1;
    wait_conv();
    t_spi();
    t_sync();
    t_abort();
    test_done();
  end
  // Watchdog
  initial begin
    #200000;
    bad_count++;
    test_done();
  end
endmodule : srp_result_port_bench
